// [design/mmd_decoder.sv]
// Summary of operation
// - vector entry is base plus twice number, 19-bit
// - vectors 40-42 converters, levels 0 to 2
// - vector 45 soft low interrupt, lowest level
// - request addresses are 24-bit word addresses; vector addresses are 19-bit
// - program 0-0x1fff flash; boot 0, watchdog 2
// - reset base overlays vectors 0,1 on reset fetches
// - program 0x8000-0x87ff is shared data RAM
// - data 0xf000-0xffff is peripheral window
// - data 0xffff00-0xffffff is debug window
// - fixed base address for each peripheral
// - timer channels take 16-word slots
// - higher level first, lower vector wins ties
`timescale 1ns/1ps
module mmd_decoder (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input mmd_pkg::mmd_req_s req_in,
  input mmd_pkg::mmd_rdata_s rdata_in,
  input wire logic [45:0] irq_pend_in,
  input wire logic [45:0][1:0] irq_level_in,
  input wire logic [18:0] vector_base_in,
  output mmd_pkg::mmd_sel_s sel_out,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output mmd_pkg::mmd_vec_s vec_out,
  output logic overlay_out
);

  // whole state of the decoder
  typedef struct packed {
    mmd_pkg::mmd_sel_s sel;
    logic [15:0] rdata;
    logic rvalid;
    mmd_pkg::mmd_vec_s vec;
    logic overlay;
    logic rsv_rd; // reserved read taken last cycle
  } mmd_state_s;

  // registered state and its next value
  mmd_state_s st_reg;
  mmd_state_s st_next;
  // combinational winner from the arbiter
  mmd_pkg::mmd_vec_s arb_vec;
  // decoded selection of the incoming request
  mmd_pkg::mmd_sel_s dec;
  // a reserved read still gets a zero answer
  logic req_read_none;

  // range test shared by every window check in decode_tgt
  function automatic logic in_range(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // top-level target from space and word address
  function automatic mmd_pkg::mmd_tgt_e decode_tgt(input logic prog,
                                                   input logic [23:0] a);
    if (prog)
    begin
      // program space
      if (in_range(a, mmd_pkg::P_FLASH_LO, mmd_pkg::P_FLASH_HI))
        return mmd_pkg::MMD_TGT_FLASH;
      if (in_range(a, mmd_pkg::P_RAM_LO, mmd_pkg::P_RAM_HI))
        return mmd_pkg::MMD_TGT_RAM;
      return mmd_pkg::MMD_TGT_NONE;
    end
    // data space
    if (in_range(a, mmd_pkg::X_RAM_LO, mmd_pkg::X_RAM_HI))
      return mmd_pkg::MMD_TGT_RAM;
    if (in_range(a, mmd_pkg::X_PER_LO, mmd_pkg::X_PER_HI))
      return mmd_pkg::MMD_TGT_PERIPH;
    if (in_range(a, mmd_pkg::X_DBG_LO, mmd_pkg::X_DBG_HI))
      return mmd_pkg::MMD_TGT_DEBUG;
    return mmd_pkg::MMD_TGT_NONE;
  endfunction : decode_tgt

  // one-hot select of the peripheral holding a window word, or zero
  function automatic logic [15:0] per_onehot(input logic [15:0] a);
    logic [15:0] oh;
    oh = 16'h0000;
    for (int i = 0; i < mmd_pkg::PER_N; i++)
    begin
      if (a >= mmd_pkg::PER_BASE[i] && a <= mmd_pkg::PER_LAST[i])
        oh[i] = 1'b1;
    end
    return oh;
  endfunction : per_onehot

  // word offset inside the selected peripheral
  function automatic logic [15:0] per_offset(input logic [15:0] a,
                                             input logic [15:0] oh);
    logic [15:0] off;
    off = 16'h0000;
    for (int i = 0; i < mmd_pkg::PER_N; i++)
    begin
      if (oh[i])
        off = a - mmd_pkg::PER_BASE[i];
    end
    return off;
  endfunction : per_offset

  // interrupt vector arbitration and address forming
  mmd_vec_arb u_vec_arb (
    .pend_in(irq_pend_in),
    .level_in(irq_level_in),
    .vector_base_in(vector_base_in),
    .vec_out(arb_vec)
  );

  // address decode of the current request
  always_comb
  begin
    dec = '0;
    dec.tgt = mmd_pkg::MMD_TGT_NONE;
    if (req_in.valid)
    begin
      // addresses are word addresses, no byte lane bits
      dec.tgt = decode_tgt(req_in.prog_space, req_in.addr);
      case (dec.tgt)
        mmd_pkg::MMD_TGT_FLASH:
        begin
          // flash word index
          dec.offset = req_in.addr[15:0];
        end
        mmd_pkg::MMD_TGT_RAM:
        begin
          // both spaces land on one array index
          dec.ram_idx = req_in.addr[10:0];
          dec.offset = {5'h00, req_in.addr[10:0]};
        end
        mmd_pkg::MMD_TGT_PERIPH:
        begin
          // single-word register access assumed
          dec.per_sel = per_onehot(req_in.addr[15:0]);
          dec.offset = per_offset(req_in.addr[15:0], dec.per_sel);
          if (dec.per_sel[mmd_pkg::PER_TIMER])
          begin
            // channel slot and register inside it
            dec.tmr_chan = dec.offset[5:4];
            if (dec.offset[3:0] > mmd_pkg::TMR_REG_LAST)
              dec.per_sel = 16'h0000;
          end
          if (dec.per_sel == 16'h0000)
          begin
            // hole in the window selects nothing
            dec.tgt = mmd_pkg::MMD_TGT_NONE;
            dec.offset = 16'h0000;
            dec.tmr_chan = 2'h0;
          end
        end
        mmd_pkg::MMD_TGT_DEBUG:
        begin
          // register index inside the debug window
          dec.offset = {8'h00, req_in.addr[7:0]};
        end
        default:
        begin
          // reserved range, nothing selected
          dec.offset = 16'h0000;
        end
      endcase
      // strobes only toward a real target
      if (dec.tgt != mmd_pkg::MMD_TGT_NONE)
      begin
        dec.wr = req_in.write;
        dec.rd = !req_in.write;
      end
    end
  end

  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.sel = dec;
    // read answer one cycle after the registered select
    st_next.rvalid = st_reg.sel.rd | st_reg.rsv_rd;
    // remember a reserved read for its zero answer
    st_next.rsv_rd = req_read_none;
    case (st_reg.sel.tgt)
      mmd_pkg::MMD_TGT_FLASH:
        st_next.rdata = rdata_in.flash;
      mmd_pkg::MMD_TGT_RAM:
        st_next.rdata = rdata_in.ram;
      mmd_pkg::MMD_TGT_PERIPH:
        st_next.rdata = rdata_in.periph;
      mmd_pkg::MMD_TGT_DEBUG:
        st_next.rdata = rdata_in.debug;
      default:
        st_next.rdata = 16'h0000;
    endcase
    if (st_reg.sel.wr)
      st_next.rvalid = 1'b0;
    // interrupt vector winner
    st_next.vec = arb_vec;
    // reset base puts entries 0 and 1 on the boot/watchdog fetches
    st_next.overlay = (vector_base_in == mmd_pkg::VEC_BASE_RST);
  end

  // flag a read toward a reserved range
  always_comb
  begin
    req_read_none = req_in.valid && !req_in.write
                    && (dec.tgt == mmd_pkg::MMD_TGT_NONE);
  end

  // state register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  always_comb
  begin
    sel_out = st_reg.sel;
    rdata_out = st_reg.rdata;
    rvalid_out = st_reg.rvalid;
    vec_out = st_reg.vec;
    overlay_out = st_reg.overlay;
  end

endmodule : mmd_decoder

// [design/mmd_pkg.sv]
package mmd_pkg;

  // word address width on the core side, both spaces
  localparam int ADDR_W = 24;
  // data word width
  localparam int DATA_W = 16;
  // reachable width of a vector table target
  localparam int VEC_ADDR_W = 19;
  // number of vector numbers handled, 0 through 45
  localparam int VEC_N = 46;
  // number of peripheral windows
  localparam int PER_N = 16;

  // program space map, word addresses
  localparam logic [23:0] P_FLASH_LO = 24'h000000;
  localparam logic [23:0] P_FLASH_HI = 24'h001fff;
  localparam logic [23:0] P_RAM_LO = 24'h008000;
  localparam logic [23:0] P_RAM_HI = 24'h0087ff;
  // boot and watchdog-reset fetch words
  localparam logic [23:0] P_BOOT_ADDR = 24'h000000;
  localparam logic [23:0] P_WDOG_ADDR = 24'h000002;

  // data space map, word addresses
  localparam logic [23:0] X_RAM_LO = 24'h000000;
  localparam logic [23:0] X_RAM_HI = 24'h0007ff;
  localparam logic [23:0] X_PER_LO = 24'h00f000;
  localparam logic [23:0] X_PER_HI = 24'h00ffff;
  localparam logic [23:0] X_DBG_LO = 24'hffff00;
  localparam logic [23:0] X_DBG_HI = 24'hffffff;

  // vector base value after reset
  localparam logic [18:0] VEC_BASE_RST = 19'h00000;
  // special vector numbers
  localparam logic [5:0] VEC_CONV_A = 6'h28;
  localparam logic [5:0] VEC_CONV_B = 6'h29;
  localparam logic [5:0] VEC_CONV_ERR = 6'h2a;
  localparam logic [5:0] VEC_SOFT_LOW = 6'h2d;
  // vectors that carry a source (reserved and overlay slots cleared)
  localparam logic [45:0] VEC_USED = 46'h3ff9ffdf3ffc;
  // highest programmable level for converter vectors
  localparam logic [1:0] LVL_CONV_MAX = 2'h2;
  // fixed core vectors 2..5 sit at level 3
  localparam logic [5:0] VEC_CORE_LO = 6'h02;
  localparam logic [5:0] VEC_CORE_HI = 6'h05;

  // timer channel slot: 16 words, registers 0x0..0xa used
  localparam logic [3:0] TMR_REG_LAST = 4'ha;

  // peripheral order in the select vector
  localparam int PER_TIMER = 0;
  localparam int PER_ICU = 2;

  // peripheral window first word
  localparam logic [15:0] PER_BASE [PER_N] = '{
    16'hf000, 16'hf040, 16'hf060, 16'hf080, 16'hf0b0, 16'hf0c0,
    16'hf0d0, 16'hf0e0, 16'hf0f0, 16'hf100, 16'hf110, 16'hf120,
    16'hf130, 16'hf140, 16'hf160, 16'hf400};
  // peripheral window last word
  localparam logic [15:0] PER_LAST [PER_N] = '{
    16'hf03f, 16'hf05f, 16'hf07f, 16'hf0af, 16'hf0bf, 16'hf0cf,
    16'hf0df, 16'hf0ef, 16'hf0ff, 16'hf10f, 16'hf11f, 16'hf12f,
    16'hf13f, 16'hf15f, 16'hf16f, 16'hf43f};

  // decoded target of one access
  typedef enum logic [2:0] {
    MMD_TGT_NONE,
    MMD_TGT_FLASH,
    MMD_TGT_RAM,
    MMD_TGT_PERIPH,
    MMD_TGT_DEBUG
  } mmd_tgt_e;

  // access request from the core
  typedef struct packed {
    logic valid;
    logic prog_space;
    logic write;
    logic [23:0] addr;
  } mmd_req_s;

  // read data returned by each target group
  typedef struct packed {
    logic [15:0] flash;
    logic [15:0] ram;
    logic [15:0] periph;
    logic [15:0] debug;
  } mmd_rdata_s;

  // decoded selection toward the targets
  typedef struct packed {
    mmd_tgt_e tgt;
    logic rd;
    logic wr;
    logic [15:0] per_sel;
    logic [15:0] offset;
    logic [10:0] ram_idx;
    logic [1:0] tmr_chan;
  } mmd_sel_s;

  // winning interrupt vector
  typedef struct packed {
    logic valid;
    logic [5:0] num;
    logic [18:0] addr;
  } mmd_vec_s;

endpackage : mmd_pkg

// [design/mmd_vec_arb.sv]
`timescale 1ns/1ps
module mmd_vec_arb (
  input wire logic [45:0] pend_in,
  input wire logic [45:0][1:0] level_in,
  input wire logic [18:0] vector_base_in,
  output mmd_pkg::mmd_vec_s vec_out
);

  // effective rank: 0 is the level below zero, 4 is level 3
  function automatic logic [2:0] rank(input logic [5:0] v,
                                      input logic [1:0] lvl);
    logic [1:0] l;
    l = lvl;
    if (v == mmd_pkg::VEC_SOFT_LOW)
      return 3'h0;
    if (v >= mmd_pkg::VEC_CORE_LO && v <= mmd_pkg::VEC_CORE_HI)
      return 3'h4;
    if (v >= mmd_pkg::VEC_CONV_A && v <= mmd_pkg::VEC_CONV_ERR
        && l > mmd_pkg::LVL_CONV_MAX)
      l = mmd_pkg::LVL_CONV_MAX;
    return {1'b0, l} + 3'h1;
  endfunction : rank

  // scan from the top so a lower number wins a tie
  always_comb
  begin
    logic [2:0] best;
    logic [2:0] r;
    best = 3'h0;
    r = 3'h0;
    vec_out = '0;
    for (int v = 45; v >= 0; v--)
    begin
      r = rank(6'(v), level_in[v]);
      if (pend_in[v] && mmd_pkg::VEC_USED[v]
          && (!vec_out.valid || r >= best))
      begin
        vec_out.valid = 1'b1;
        vec_out.num = 6'(v);
        best = r;
      end
    end
    // two words per entry, 19-bit reach
    vec_out.addr = vector_base_in + {12'h000, vec_out.num, 1'b0};
  end

endmodule : mmd_vec_arb

// [test/mmd_decoder_sva.sv]
`timescale 1ns/1ps
module mmd_chk (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input mmd_pkg::mmd_req_s req_in,
  input wire logic [45:0] irq_pend_in,
  input wire logic [18:0] vector_base_in,
  input mmd_pkg::mmd_sel_s sel_out,
  input wire logic [15:0] rdata_out,
  input wire logic rvalid_out,
  input mmd_pkg::mmd_vec_s vec_out,
  input wire logic overlay_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // request fields
  wire logic rq = req_in.valid;
  wire logic pg = req_in.prog_space;
  wire logic [23:0] ad = req_in.addr;
  // program access into a reserved range
  wire logic rsv = rq && pg && ad[23:13] != 0 && ad[23:11] != 13'h10;
  a_flash_sel: assert property (rq && pg && ad < 24'h2000
    |=> sel_out.tgt == mmd_pkg::MMD_TGT_FLASH) else $error("no flash");
  a_ram_shared: assert property (rq && ad[23:11] == {8'h0, pg, 4'h0}
    |=> sel_out.tgt == mmd_pkg::MMD_TGT_RAM
    && sel_out.ram_idx == $past(ad[10:0])) else $error("bad ram");
  a_dbg_win: assert property (rq && !pg && ad >= 24'hffff00
    |=> sel_out.tgt == mmd_pkg::MMD_TGT_DEBUG) else $error("no debug");
  a_per_win: assert property (rq && !pg && ad[23:12] == 12'h00f
    |=> sel_out.tgt inside {mmd_pkg::MMD_TGT_PERIPH,
    mmd_pkg::MMD_TGT_NONE}) else $error("bad periph window");
  a_rsvd_none: assert property (rsv
    |=> sel_out.tgt == mmd_pkg::MMD_TGT_NONE && !sel_out.rd
    && !sel_out.wr) else $error("reserved selected");
  a_rsvd_zero: assert property (rsv && !req_in.write
    |-> ##2 rvalid_out && rdata_out == 16'h0) else $error("rsv data");
  a_sel_onehot: assert property (sel_out.tgt ==
    mmd_pkg::MMD_TGT_PERIPH |-> $onehot(sel_out.per_sel))
    else $error("periph select not one-hot");
  a_timer_base: assert property (rq && !pg && ad == 24'h00f000
    |=> sel_out.per_sel[0]) else $error("timer base");
  a_tmr_slot: assert property (rq && !pg && ad[23:6] == 18'h3c0
    && ad[3:0] > 4'ha |=> sel_out.tgt == mmd_pkg::MMD_TGT_NONE)
    else $error("timer hole");
  a_vec_addr: assert property (vec_out.valid |-> vec_out.addr ==
    19'($past(vector_base_in) + {vec_out.num, 1'b0}))
    else $error("vector address");
  a_vec_overlay: assert property (!$past(rst_in) |-> overlay_out
    == ($past(vector_base_in) == 19'h0)) else $error("overlay");
  a_soft_low: assert property (vec_out.valid && vec_out.num == 6'h2d
    |-> ($past(irq_pend_in) & mmd_pkg::VEC_USED) == {1'b1, 45'h0})
    else $error("low vector won early");
  c_flash_rd: cover property (sel_out.rd
    && sel_out.tgt == mmd_pkg::MMD_TGT_FLASH);
  c_per_wr: cover property (sel_out.wr
    && sel_out.tgt == mmd_pkg::MMD_TGT_PERIPH);
  c_vec_low: cover property (vec_out.valid && vec_out.num == 6'h2d);
endmodule : mmd_chk
bind mmd_decoder mmd_chk chk_u (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .req_in(req_in), .irq_pend_in(irq_pend_in),
  .vector_base_in(vector_base_in), .sel_out(sel_out),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .vec_out(vec_out), .overlay_out(overlay_out));

// [test/mmd_mem_model.sv]
`timescale 1ns/1ps
module mmd_mem_model (
  input wire logic sys_clk_in,
  input mmd_pkg::mmd_sel_s sel_in,
  output mmd_pkg::mmd_rdata_s rdata_out
);
  logic [15:0] junk_reg = 16'h0; // idle bus pattern
  // unselected targets show a pattern that moves every cycle
  always_ff @(posedge sys_clk_in)
  begin
    junk_reg <= junk_reg + 16'h1357;
  end
  // selected target answers in the cycle of the read strobe
  always_comb
  begin
    rdata_out = {4{junk_reg}};
    if (sel_in.rd)
    begin
      case (sel_in.tgt)
        mmd_pkg::MMD_TGT_FLASH: rdata_out.flash = sel_in.offset ^ 16'ha5a5;
        mmd_pkg::MMD_TGT_RAM: rdata_out.ram = {5'h0, sel_in.ram_idx};
        mmd_pkg::MMD_TGT_PERIPH: rdata_out.periph = 16'h3c3c;
        mmd_pkg::MMD_TGT_DEBUG: rdata_out.debug = 16'hc3c3;
        default: ;
      endcase
    end
  end
endmodule : mmd_mem_model

// [test/tb_memory_map_address_decoder.sv]
`timescale 1ns/1ps
module tb_memory_map_address_decoder;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  mmd_pkg::mmd_req_s req = '0;
  mmd_pkg::mmd_rdata_s rdata;
  mmd_pkg::mmd_sel_s sel;
  mmd_pkg::mmd_vec_s vec;
  logic [45:0] pend = '0;
  logic [45:0][1:0] lvl = '0;
  logic [18:0] vbase = '0;
  logic [15:0] rdo;
  logic rvo;
  logic ovl; // vector base at its reset value
  logic [15:0] rnd = 16'h0028; // random source
  logic vp = 1'b0; // request taken last edge
  logic vvp = 1'b0; // vector valid last edge
  logic [22:0] e;
  logic [22:0] tq[$]; // expected target, select, strobes, channel
  logic [15:0] dq[$]; // expected read data
  logic [25:0] vq[$]; // expected overlay and vector
  int fails = 0;
  int comparisons = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  mmd_decoder dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .req_in(req), .rdata_in(rdata), .irq_pend_in(pend),
    .irq_level_in(lvl), .vector_base_in(vbase), .sel_out(sel),
    .rdata_out(rdo), .rvalid_out(rvo), .vec_out(vec),
    .overlay_out(ovl));
  mmd_mem_model mem_u (.sys_clk_in(sys_clk_in), .sel_in(sel),
    .rdata_out(rdata));
  function logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one single-word access, expectation noted first
  task acc(input logic p, input logic w, input logic [23:0] a);
    mmd_pkg::mmd_tgt_e t;
    logic [15:0] ps;
    logic [15:0] d;
    logic [1:0] ch;
    t = mmd_pkg::MMD_TGT_NONE;
    ps = 16'h0;
    d = 16'h0;
    ch = 2'h0;
    if (p && a < 24'h2000)
    begin
      t = mmd_pkg::MMD_TGT_FLASH;
      d = a[15:0] ^ 16'ha5a5;
    end
    else if (a[23:11] == {8'h0, p, 4'h0})
    begin
      t = mmd_pkg::MMD_TGT_RAM;
      d = {5'h0, a[10:0]};
    end
    else if (!p && a >= 24'hffff00)
    begin
      t = mmd_pkg::MMD_TGT_DEBUG;
      d = 16'hc3c3;
    end
    else if (!p && a[23:16] == 8'h0)
      for (int i = 0; i < mmd_pkg::PER_N; i++)
        if (a[15:0] >= mmd_pkg::PER_BASE[i] && !(i == 0 && a[3:0] > 4'ha)
          && a[15:0] <= mmd_pkg::PER_LAST[i])
        begin
          t = mmd_pkg::MMD_TGT_PERIPH;
          ps = 16'h1 << i;
          d = 16'h3c3c;
          ch = (i == 0) ? a[5:4] : 2'h0;
        end
    tq.push_back({t, ps, t != mmd_pkg::MMD_TGT_NONE && !w,
      t != mmd_pkg::MMD_TGT_NONE && w, ch});
    if (!w)
      dq.push_back(d);
    req = {1'b1, p, w, a};
    @(posedge sys_clk_in);
    #1;
  endtask : acc
  // hold interrupt inputs, then release them
  task vtest(input logic [5:0] n);
    vq.push_back({vbase == 19'h0, n, 19'(vbase + {n, 1'b0})});
    repeat (3) @(posedge sys_clk_in);
    #1;
    pend = '0;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : vtest
  // compare each answer with the oldest note
  always @(posedge sys_clk_in)
  begin
    if (vp)
    begin
      e = tq.pop_front();
      chk({sel.tgt, sel.per_sel, sel.rd, sel.wr, sel.tmr_chan}, e);
    end
    vp <= req.valid;
    if (rvo)
      chk(rdo, dq.pop_front());
    if (vec.valid && !vvp)
      chk({ovl, vec.num, vec.addr}, vq.pop_front());
    vvp <= vec.valid;
  end
  task test_done;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    #200000;
    fails++;
    test_done;
  end
  initial
  begin
    repeat (10) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    for (int i = 0; i < mmd_pkg::PER_N; i++)
      acc(1'b0, 1'b0, {8'h0, mmd_pkg::PER_BASE[i]});
    acc(1'b1, 1'b0, 24'h2);
    for (int i = 0; i < 80; i++)
    begin
      rnd = lfsr(rnd);
      case (rnd[2:0])
        3'h0: acc(1'b1, rnd[15], {11'h0, rnd[15:3]});
        3'h1: acc(1'b1, rnd[15], {13'h10, rnd[13:3]});
        3'h2: acc(1'b0, rnd[15], {13'h0, rnd[13:3]});
        3'h3: acc(1'b0, rnd[15], {18'h3c0, rnd[8:3]});
        3'h4: acc(1'b0, rnd[15], {16'hffff, rnd[10:3]});
        3'h5: acc(1'b0, rnd[15], {12'hf, rnd[14:3]});
        3'h6: acc(1'b1, rnd[15], {11'h1, rnd[15:3]});
        default: acc(1'b0, rnd[15], {8'h1, rnd});
      endcase
    end
    req.valid = 1'b0;
    pend[13] = 1'b1;
    pend[45] = 1'b1;
    vtest(6'd13);
    vbase = {rnd[2:0], rnd};
    pend[45] = 1'b1;
    vtest(6'd45);
    lvl[36] = 2'h2;
    lvl[40] = 2'h3;
    pend = 46'h7 << 40 | 46'h1 << 36;
    vtest(6'd36);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      vbase = {rnd[2:0], rnd};
      lvl = '0;
      lvl[40 + k] = 2'h2;
      pend = 46'h7 << 40;
      vtest(6'(40 + k));
    end
    // every noted result must have come back
    chk(tq.size(), 0);
    chk(dq.size(), 0);
    chk(vq.size(), 0);
    test_done;
  end
endmodule : tb_memory_map_address_decoder
